// File: dv/slod_encoder_model.sv
// Incremental encoder model driving both quadrature channels
`timescale 1ns/1ps
module slod_encoder_model (
  input wire logic pclk,
  input wire logic step,
  input wire logic dir,
  output logic encoder_channel_a,
  output logic encoder_channel_b
);
  logic [1:0] ph_reg; // Quadrature phase
  initial ph_reg = 2'h0;
  // One channel edge per step, A leads B when dir is high
  always @(posedge pclk) begin
    if (step) begin
      ph_reg <= dir ? ph_reg + 2'h1 : ph_reg - 2'h1;
    end
  end
  // Gray decode so only one channel moves per step
  assign encoder_channel_a = ph_reg[1] ^ ph_reg[0];
  assign encoder_channel_b = ph_reg[1];
endmodule

// File: dv/slod_servo_loop_asserts.sv
// Port checker of the servo loop datapath
`timescale 1ns/1ps
module slod_servo_loop_asserts #(
  parameter int CYC_SHORT = 20,
  parameter int CYC_LONG = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [11:0] dac_code,
  input wire logic dac_load
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] gap_reg; // Cycles since last converter update
  logic gain_reg; // A nonzero gain was written
  logic long_reg; // Long period was ever chosen
  wire wr = psel && penable && pready && pwrite;
  // Update gap, restarts at each load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_reg <= 32'h0;
    else gap_reg <= dac_load ? 32'h0 : gap_reg + 32'h1;
  end
  // Sticky flags; slack of four covers the three-stage pipe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reg <= 1'b0;
      long_reg <= 1'b0;
    end else if (wr) begin
      if (paddr inside {8'h04, 8'h08, 8'h0C, 8'h10} && pwdata[15:0] != 16'h0) gain_reg <= 1'b1;
      if (paddr == slod_pkg::OFS_CTRL && pwdata[0]) long_reg <= 1'b1;
    end
  end
  pready_setup_a: assert property (psel && !penable |=> pready) else $error("no answer");
  pready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  slverr_map_a: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > slod_pkg::OFS_FERR)) else $error("bad slverr");
  err_rdata_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  load_pulse_a: assert property (dac_load |=> !dac_load) else $error("long load");
  code_hold_a: assert property (!$stable(dac_code) |-> dac_load) else $error("code moved");
  gain_zero_a: assert property (!gain_reg |-> dac_code == 12'sh000) else $error("nonzero");
  period_short_a: assert property (!long_reg |-> gap_reg <= CYC_SHORT + 4)
    else $error("short period late");
  period_long_a: assert property (gap_reg <= CYC_LONG + 4) else $error("period late");
endmodule
bind slod_servo_loop slod_servo_loop_asserts #(.CYC_SHORT(CYC_SHORT), .CYC_LONG(CYC_LONG)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dac_code(dac_code), .dac_load(dac_load));

// File: dv/testbench.sv
// Self-checking bench of the servo loop datapath
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module testbench;
  localparam int CS = 20; // Shortened periods keep the run brief
  localparam int CL = 40;
  logic pclk, presetn, psel, penable, pwrite, step, dir, perr, pready, pslverr, dac_load;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, pos;
  logic signed [11:0] dac_code;
  logic enc_a, enc_b;
  int miscompares, comparisons, cyc, c, k, v;
  int vt[4] = '{2047, -2048, 3000, -3000}; // Full scale and overflow corners
  slod_servo_loop #(.CYC_SHORT(CS), .CYC_LONG(CL)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .encoder_channel_a(enc_a),
    .encoder_channel_b(enc_b), .dac_code(dac_code), .dac_load(dac_load));
  slod_encoder_model u_enc (.pclk(pclk), .step(step), .dir(dir),
    .encoder_channel_a(enc_a), .encoder_channel_b(enc_b));
  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      conclude();
    end
  end
  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected code: Q8.8 shift then clamp
  function automatic logic signed [11:0] sat(input longint p);
    longint s;
    s = p >>> slod_pkg::GAIN_FRAC;
    if (s > 2047) return slod_pkg::DAC_MAX;
    if (s < -2048) return slod_pkg::DAC_MIN;
    return s[11:0];
  endfunction
  // One APB transfer, waits on pready, then idles a cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Cycles until the next converter update
  task automatic gap(output int g);
    g = 0;
    do begin @(posedge pclk); g++; end while (dac_load !== 1'b1 && g < 200);
  endtask
  // Turn the encoder n lines, four edges each
  task automatic lines(input int n, input logic d);
    dir <= d;
    repeat (4 * n) begin
      step <= 1'b1;
      @(posedge pclk);
      step <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; step = 0; dir = 1;
    presetn = 0; seed = 32'h0000_91F9;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and unmapped access
    apb(0, slod_pkg::OFS_CTRL, 0); `CHK("ctrl", slod_pkg::CTRL_RESET, rd)
    for (int i = 1; i < 5; i++) begin apb(0, 8'(4 * i), 0); `CHK("gain", 32'h0, rd) end
    gap(c); `CHK("dac0", 12'sh000, dac_code)
    apb(1, 8'h40, 32'hFFFF_FFFF); `CHK("slverr", 1'b1, perr)
    apb(0, 8'h40, 0); `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    // Four counts per line both ways
    k = int'(xs() % 8) + 1;
    lines(k, 1); apb(0, slod_pkg::OFS_POS, 0); `CHK("pos_up", 32'(4 * k), rd)
    lines(k + 2, 0); apb(0, slod_pkg::OFS_POS, 0); `CHK("pos_dn", 32'(-8), rd)
    $display("test encoder done");
    // Feed-forward alone, random then corners, untouched by motion
    for (int i = 0; i < 8; i++) begin
      k = (i < 4) ? int'(xs() % 2048) - 1024 : 256;
      v = (i < 4) ? int'(xs() % 512) - 256 : vt[i - 4];
      apb(1, slod_pkg::OFS_KFF, 32'(k)); apb(1, slod_pkg::OFS_DEMVEL, 32'(v));
      gap(c); gap(c); `CHK("ff", sat(longint'(k) * v), dac_code)
      lines(2, i[0]); gap(c); `CHK("ff_fb", sat(longint'(k) * v), dac_code)
    end
    $display("test feedforward done");
    // Following error into proportional term
    apb(1, slod_pkg::OFS_KFF, 0); apb(1, slod_pkg::OFS_KP, 32'h0000_0100);
    apb(0, slod_pkg::OFS_POS, 0); pos = rd;
    v = int'(xs() % 1000) - 500;
    apb(1, slod_pkg::OFS_DEMPOS, pos + 32'(v));
    gap(c); gap(c); `CHK("kp", sat(longint'(256) * v), dac_code)
    apb(0, slod_pkg::OFS_FERR, 0); `CHK("ferr", 32'(v), rd)
    $display("test error done");
    // Period selection both ways
    apb(1, slod_pkg::OFS_CTRL, 32'h0000_0003);
    gap(c); gap(c); gap(c); `CHK("p2", CL, c)
    apb(1, slod_pkg::OFS_CTRL, 32'h0000_0000);
    gap(c); gap(c); gap(c); `CHK("p1", CS, c)
    `CHK("off", 12'sh000, dac_code)
    apb(0, slod_pkg::OFS_DAC, 0); `CHK("dac_rd", 32'h0, rd)
    apb(1, slod_pkg::OFS_CTRL, 32'h0000_0002);
    gap(c); gap(c); `CHK("on", 12'(v), dac_code)
    $display("test period done");
    conclude();
  end
endmodule

// File: rtl/slod_period_timer.sv
// Servo period tick generator with 1 ms or 2 ms selection
`timescale 1ns/1ps
module slod_period_timer #(
  parameter int CYC_SHORT = slod_pkg::CYC_1MS,
  parameter int CYC_LONG = slod_pkg::CYC_2MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic servo_period_select,
  output logic tick
);

  // Wide enough for the longer period
  localparam int CW = $clog2(CYC_LONG + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] limit;

  // Terminal count follows the selection at once, also for the period in progress
  assign limit = servo_period_select ? CW'(CYC_LONG - 1) : CW'(CYC_SHORT - 1);

  // Free-running counter, one tick per servo period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule

// File: rtl/slod_pkg.sv
// Package of constants and carrier types for the servo loop output datapath
package slod_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KP = 8'h04;
  localparam logic [7:0] OFS_KD = 8'h08;
  localparam logic [7:0] OFS_KV = 8'h0C;
  localparam logic [7:0] OFS_KFF = 8'h10;
  localparam logic [7:0] OFS_DEMPOS = 8'h14;
  localparam logic [7:0] OFS_DEMVEL = 8'h18;
  localparam logic [7:0] OFS_POS = 8'h1C;
  localparam logic [7:0] OFS_DAC = 8'h20;
  localparam logic [7:0] OFS_FERR = 8'h24;

  // Control register field positions and reset values
  localparam int CTRL_PERIOD_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam logic [15:0] GAIN_RESET = 16'h0000;

  // Gain format: signed Q8.8, product shifted right by this many bits
  localparam int GAIN_FRAC = 8;

  // Converter code range, full scale at magnitude 2048
  localparam int DAC_W = 12;
  localparam int DAC_FULL_SCALE = 2048;
  localparam logic signed [11:0] DAC_MAX = 12'sh7FF;
  localparam logic signed [11:0] DAC_MIN = 12'sh800;

  // Quadrature counts per encoder line
  localparam int QUAD_PER_LINE = 4;

  // Servo period timing
  localparam int CLK_HZ = 40_000_000;
  localparam int PERIOD_1MS_US = 1000;
  localparam int PERIOD_2MS_US = 2000;
  localparam int CYC_1MS = CLK_HZ / 1_000_000 * PERIOD_1MS_US;
  localparam int CYC_2MS = CLK_HZ / 1_000_000 * PERIOD_2MS_US;

  // Servo gain set carried as one bundle
  typedef struct packed {
    logic signed [15:0] prop;
    logic signed [15:0] deriv;
    logic signed [15:0] velfb;
    logic signed [15:0] velff;
  } slod_gains_s;

  // Loop command inputs from the profile side
  typedef struct packed {
    logic signed [31:0] pos;
    logic signed [15:0] vel;
  } slod_demand_s;

  // Loop computation state
  typedef enum logic [1:0] {
    SL_IDLE,
    SL_SUM,
    SL_OUT
  } slod_state_e;

endpackage

// File: rtl/slod_quad_counter.sv
// Four-times quadrature decoder and signed position counter
`timescale 1ns/1ps
module slod_quad_counter #(
  parameter int CNT_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic encoder_channel_a,
  input wire logic encoder_channel_b,
  output logic signed [CNT_W-1:0] count
);

  // Two-stage synchronisers, first stages read only by the second
  logic a_meta_reg;
  logic b_meta_reg;
  logic a_sync_reg;
  logic b_sync_reg;
  // Previous synchronised levels for edge detection
  logic a_prev_reg;
  logic b_prev_reg;
  logic step_up;
  logic step_dn;

  // Synchroniser stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_meta_reg <= 1'b0;
      b_meta_reg <= 1'b0;
      a_sync_reg <= 1'b0;
      b_sync_reg <= 1'b0;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_meta_reg <= encoder_channel_a;
      b_meta_reg <= encoder_channel_b;
      a_sync_reg <= a_meta_reg;
      b_sync_reg <= b_meta_reg;
      a_prev_reg <= a_sync_reg;
      b_prev_reg <= b_sync_reg;
    end
  end

  // Direction from old and new Gray state; any edge of either channel steps
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case ({a_prev_reg, b_prev_reg, a_sync_reg, b_sync_reg})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step_up = 1'b1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step_dn = 1'b1;
      default: begin
        // No change or illegal double transition: hold
        step_up = 1'b0;
      end
    endcase
  end

  // Position counter, four counts per encoder line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (step_up) begin
      count <= count + CNT_W'(1);
    end else if (step_dn) begin
      count <= count - CNT_W'(1);
    end
  end

endmodule

// File: rtl/slod_servo_loop.sv
// Servo loop datapath: APB registers, encoder count, PD + feed-forward, DAC code
//
// Operation
// - Gains reset to zero, demand zero
// - Count every edge of both channels
// - Demand is signed 12-bit converter code
// - Code 2048 magnitude means full scale
// - Add velocity demand times feed-forward gain
// - Feed-forward independent of any feedback
// - Velocities in counts per servo cycle
// - Servo period resets to 1 ms
// - Period selectable 1 ms or 2 ms
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
// Datapath outline
// One servo cycle runs in three states after each period tick
// Idle waits for the tick and samples position and error
// Sum adds the four gain-scaled terms in one wide adder
// Out shifts, clamps and loads the converter code
// Every gain is signed Q8.8, so 16'h0100 is unity gain
// Velocities are counts per servo cycle, not per second
// Hazard: a gain written mid-cycle is used from the next sum
// Trade-off: one multiplier per term for a short, fixed latency
// Limitation: no integral term and no acceleration feed-forward
module slod_servo_loop #(
  parameter int CYC_SHORT = slod_pkg::CYC_1MS,
  parameter int CYC_LONG = slod_pkg::CYC_2MS
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder pins
  input wire logic encoder_channel_a,
  input wire logic encoder_channel_b,
  // Converter code and update strobe
  output logic signed [11:0] dac_code,
  output logic dac_load
);

  // Registers written over the bus
  // All of them reset before the first tick can fire
  // Read back unchanged, gains sign-extended to 32 bits
  // Software-visible state
  slod_pkg::slod_gains_s gains_reg; // Loop gains
  slod_pkg::slod_demand_s demand_reg; // Profile demand in counts
  logic servo_period_select_reg; // Period select, 0 is 1 ms
  logic loop_enable_reg; // Output enable, low forces zero code

  // Loop pipeline
  // Samples move only at a tick, so reads between ticks are stable
  // Sum is kept wide so no term overflows before the clamp
  // Loop state
  slod_pkg::slod_state_e state_reg;
  logic signed [31:0] position;
  logic signed [31:0] pos_latch_reg; // Position sampled at tick
  logic signed [31:0] prev_pos_reg; // Position at previous tick
  logic signed [31:0] ferr_reg; // Following error
  logic signed [31:0] prev_ferr_reg; // Previous following error
  logic signed [31:0] mvel_reg; // Measured velocity
  logic signed [47:0] sum_reg; // Summed terms, gain scaled
  logic tick;

  // Bus decode
  // Writes land at the access edge, reads are staged at setup
  // No wait states, so pready is a one-cycle pulse
  // APB access phase
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Multiplier helper
  // Both operands sign-extended before the product
  // The fraction is dropped once, after the sum, not per term
  // Scale a 32-bit value by a Q8.8 gain; used for every term
  function automatic logic signed [47:0] term(input logic signed [31:0] v,
                                              input logic signed [15:0] g);
    logic signed [47:0] p;
    p = 48'(v) * 48'(g);
    return p;
  endfunction

  // Output limiter
  // Saturates instead of wrapping, so overflow cannot flip sign
  // Plus full scale lands on the largest positive code
  // Clamp a scaled sum to the signed converter code range
  function automatic logic signed [11:0] clamp12(input logic signed [47:0] s);
    logic signed [47:0] q;
    q = s >>> slod_pkg::GAIN_FRAC;
    if (q > 48'(slod_pkg::DAC_MAX)) begin
      return slod_pkg::DAC_MAX;
    end else if (q < 48'(slod_pkg::DAC_MIN)) begin
      return slod_pkg::DAC_MIN;
    end else begin
      return q[11:0];
    end
  endfunction

  // Map check
  // Unknown offsets raise pslverr with the ready pulse
  // Read-only offsets are mapped, their writes just do nothing
  // Address decode: known offsets only
  always_comb begin
    case (paddr)
      slod_pkg::OFS_CTRL, slod_pkg::OFS_KP, slod_pkg::OFS_KD, slod_pkg::OFS_KV,
      slod_pkg::OFS_KFF, slod_pkg::OFS_DEMPOS, slod_pkg::OFS_DEMVEL,
      slod_pkg::OFS_POS, slod_pkg::OFS_DAC, slod_pkg::OFS_FERR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Position feedback
  // Pins are synchronised inside the counter
  // Count lags a pin edge by three clocks
  // Encoder position counter
  slod_quad_counter #(
    .CNT_W(32)
  ) u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .encoder_channel_a(encoder_channel_a),
    .encoder_channel_b(encoder_channel_b),
    .count(position)
  );

  // Period source
  // Runs from reset, independent of the enable bit
  // A new selection applies at once, to the period in progress
  // Servo period ticks
  slod_period_timer #(
    .CYC_SHORT(CYC_SHORT),
    .CYC_LONG(CYC_LONG)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .servo_period_select(servo_period_select_reg),
    .tick(tick)
  );

  // Gain storage
  // Low half-word only, upper bits of the write ignored
  // Zero gains at reset keep the converter at zero
  // Gain registers, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gains_reg <= '{default: slod_pkg::GAIN_RESET};
    end else if (wr_en) begin
      case (paddr)
        slod_pkg::OFS_KP: gains_reg.prop <= pwdata[15:0];
        slod_pkg::OFS_KD: gains_reg.deriv <= pwdata[15:0];
        slod_pkg::OFS_KV: gains_reg.velfb <= pwdata[15:0];
        slod_pkg::OFS_KFF: gains_reg.velff <= pwdata[15:0];
        // Other offsets leave the gains alone
        default: gains_reg <= gains_reg;
      endcase
    end
  end

  // Control and demand storage
  // Enable resets high so gains alone decide the output
  // Demand position is a full 32-bit count
  // Control and demand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_period_select_reg <= slod_pkg::CTRL_RESET[slod_pkg::CTRL_PERIOD_BIT];
      loop_enable_reg <= slod_pkg::CTRL_RESET[slod_pkg::CTRL_ENABLE_BIT];
      demand_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        slod_pkg::OFS_CTRL: begin
          servo_period_select_reg <= pwdata[slod_pkg::CTRL_PERIOD_BIT];
          loop_enable_reg <= pwdata[slod_pkg::CTRL_ENABLE_BIT];
        end
        slod_pkg::OFS_DEMPOS: demand_reg.pos <= pwdata;
        // Velocity demand is counts per servo cycle
        slod_pkg::OFS_DEMVEL: demand_reg.vel <= pwdata[15:0];
        default: demand_reg <= demand_reg;
      endcase
    end
  end

  // Read path
  // Data is registered at setup and stands in the access cycle
  // Idle cycles and writes return zero on prdata
  // Position is read live, error and code as last sampled
  // APB read data and response; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          slod_pkg::OFS_CTRL: prdata <= {30'h0, loop_enable_reg, servo_period_select_reg};
          slod_pkg::OFS_KP: prdata <= 32'(gains_reg.prop);
          slod_pkg::OFS_KD: prdata <= 32'(gains_reg.deriv);
          slod_pkg::OFS_KV: prdata <= 32'(gains_reg.velfb);
          slod_pkg::OFS_KFF: prdata <= 32'(gains_reg.velff);
          slod_pkg::OFS_DEMPOS: prdata <= demand_reg.pos;
          slod_pkg::OFS_DEMVEL: prdata <= 32'(demand_reg.vel);
          slod_pkg::OFS_POS: prdata <= position;
          slod_pkg::OFS_DAC: prdata <= 32'(dac_code);
          slod_pkg::OFS_FERR: prdata <= ferr_reg;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sequencer
  // Three cycles from tick to load, far below any period
  // A tick while busy cannot occur with periods this long
  // Loop sequencer: sample, sum, output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= slod_pkg::SL_IDLE;
    end else begin
      case (state_reg)
        slod_pkg::SL_IDLE: if (tick) state_reg <= slod_pkg::SL_SUM;
        // Sum stage always lasts one cycle
        slod_pkg::SL_SUM: state_reg <= slod_pkg::SL_OUT;
        // Output stage returns to wait for the next tick
        slod_pkg::SL_OUT: state_reg <= slod_pkg::SL_IDLE;
        // Unreachable codes recover to idle
        default: state_reg <= slod_pkg::SL_IDLE;
      endcase
    end
  end

  // Sampler
  // Error and velocity use the same position sample
  // Previous error feeds the derivative difference
  // Sample position, error and measured velocity at each tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_latch_reg <= '0;
      prev_pos_reg <= '0;
      ferr_reg <= '0;
      prev_ferr_reg <= '0;
      mvel_reg <= '0;
    end else if (state_reg == slod_pkg::SL_IDLE && tick) begin
      pos_latch_reg <= position;
      prev_pos_reg <= pos_latch_reg;
      // Counts per servo cycle from successive samples
      mvel_reg <= position - pos_latch_reg;
      ferr_reg <= demand_reg.pos - position;
      prev_ferr_reg <= ferr_reg;
    end
  end

  // Adder
  // Velocity feedback subtracts, damping motion
  // Feed-forward sits outside the loop, demand only
  // Sum proportional, derivative, velocity feedback and feed-forward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_reg <= '0;
    end else if (state_reg == slod_pkg::SL_SUM) begin
      sum_reg <= term(ferr_reg, gains_reg.prop)
               + term(ferr_reg - prev_ferr_reg, gains_reg.deriv)
               - term(mvel_reg, gains_reg.velfb)
               // Demand velocity only, no feedback in this term
               + term(32'(demand_reg.vel), gains_reg.velff);
    end
  end

  // Converter drive
  // Code holds between loads, strobe marks each update
  // Disabled loop still pulses the strobe with a zero code
  // Converter code and load strobe; zero gains give zero code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code <= 12'sh000;
      dac_load <= 1'b0;
    end else if (state_reg == slod_pkg::SL_OUT) begin
      dac_code <= loop_enable_reg ? clamp12(sum_reg) : 12'sh000;
      dac_load <= 1'b1;
    end else begin
      dac_load <= 1'b0;
    end
  end

  // Limitation: one axis per instance
  // Instantiate once per axis with its own encoder pins
  // Periods are parameters so benches can shorten them

endmodule
